// ---- hw/adc_mux_frame_sequencer.sv ----
// converter input multiplexer frame sequencer with its control fields
// assumes: AHB-Lite single word transfers, slow_clock synchronous to ref_clk
// Function
// - slot length is (3-2*pll)*(fir+1)*(div+1) slow cycles
// - frame is (3-2*pll) plus slot length times slot count
// - frame in filter cycles is slow length times (48+102*pll)
// - slot count sets slots per frame, eleven at most
// - slot n converts the handle in its select field, 0 to 10
// - remote currents bypass the mux, taken in second frame half
// - remote samples go to their fixed RAM place automatically unless a filter result is stored in the same cycle
// - all fields read zero after reset and wake, all read/write
// - four enables make pairs 0-1,2-3,4-5,6-7 differential
// - three enables turn pairs 2-3,4-5,6-7 into remote links
// - preamp enable gives gain 8 on pair 0-1, else unity
// - preamp works with or without pair 0-1 differential
// - preamp and converter bias follow the clock divide bit
// - divide sets converter clock rate, pll select main clock
// - two-bit length code sets the filter span
// - each slot starts on a slow clock rising edge
// - (3-2*pll) extra slow cycles after last slot, frame_sync high in the first
// - filter result shifted left 9, stored at handle's place
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module adc_mux_frame_sequencer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic batteryWake,
  input wire logic slowClock,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [21:0] firResult,
  input wire logic firResultValid,
  input wire logic remoteSampleValid,
  input wire logic [1:0] remoteSampleChannel,
  input wire logic [21:0] remoteSampleData,
  output adc_seq_pkg::handle_t adcInputSelect,
  output logic convertStart,
  output logic conversionActive,
  output logic frameSync,
  output logic [3:0] currentSlot,
  output logic remoteSampleWindow,
  output logic sampleRamWrite,
  output adc_seq_pkg::handle_t sampleRamAddr,
  output adc_seq_pkg::sample_t sampleRamData,
  output logic [3:0] differentialEnable,
  output logic [2:0] remoteSensorEnable,
  output logic [3:0] preampGain,
  output logic biasReduced,
  output logic converterClockDivide,
  output logic pllFastSelect,
  output logic [1:0] firLengthCode,
  output logic [15:0] frameFirCycles
);
  import adc_seq_pkg::*;

  // configuration fields
  logic [3:0] slotSel [0:10];
  logic [3:0] slotCount;
  logic [1:0] firLen;
  logic [3:0] diffEn;
  logic pllFast, adcDiv, preEn;
  logic [2:0] rmtEn;
  // bus and sequencer state
  logic apValid, apWrite;
  logic [15:0] apIdx;
  seqState_t state;
  logic slowPrev, slowEdge, countWrite;
  logic [4:0] slotTimer, slotLenNow;
  logic [1:0] gapTimer, gapNow;
  logic [8:0] frameTick, frameLenNow;
  logic [3:0] effCount;
  logic [7:0] wdata;

  // slot length in slow cycles
  function automatic logic [4:0] slotLen(input logic [1:0] fir,
      input logic div, input logic pll);
    logic [4:0] g, f, d;
    g = pll ? 5'h01 : 5'h03;
    f = {3'h0, fir} + 5'h01;
    d = {4'h0, div} + 5'h01;
    return g * f * d;
  endfunction

  // word index of a bus address, all ones when misaligned or too high
  function automatic logic [15:0] wordIndex(input logic [31:0] a);
    if (a[1:0] != 2'h0 || a[31:18] != 14'h0) begin
      return 16'hFFFF;
    end
    return a[17:2];
  endfunction

  // register read image, reserved and unmapped bits zero
  function automatic logic [7:0] regRead(input logic [15:0] idx);
    case (idx)
      `IDX_SEL10_COUNT: return {slotCount, slotSel[10]};
      `IDX_SEL8_9: return {slotSel[9], slotSel[8]};
      `IDX_SEL6_7: return {slotSel[7], slotSel[6]};
      `IDX_SEL4_5: return {slotSel[5], slotSel[4]};
      `IDX_SEL2_3: return {slotSel[3], slotSel[2]};
      `IDX_SEL0_1: return {slotSel[1], slotSel[0]};
      `IDX_FIR_DIFF: return {diffEn, 1'b0, firLen, 1'b0};
      `IDX_CLOCKS: return {2'h0, adcDiv, pllFast, 4'h0};
      `IDX_PREAMP: return {2'h0, preEn, 5'h00};
      `IDX_REMOTE: return {2'h0, rmtEn, 3'h0};
      `IDX_STATUS: return {1'b0, remoteSampleWindow, frameSync,
                           conversionActive, currentSlot};
      default: return 8'h00;
    endcase
  endfunction

  // derived timing; counts above eleven behave as eleven
  always_comb begin
    gapNow = pllFast ? 2'h1 : `GAP_SLOW;
    slotLenNow = slotLen(firLen, adcDiv, pllFast);
    effCount = (slotCount > `MAX_SLOTS) ? `MAX_SLOTS : slotCount;
    frameLenNow = {7'h00, gapNow} +
                  9'(9'(slotLenNow) * 9'(effCount));
    wdata = hwdata[7:0];
    countWrite = apValid && apWrite && apIdx == `IDX_SEL10_COUNT;
    slowEdge = slowClock && !slowPrev;
  end

  // address phase capture; slave never inserts wait states
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      apValid <= 1'b0;
      apWrite <= 1'b0;
      apIdx <= 16'h0000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        apValid <= hsel && htrans[1];
        apWrite <= hwrite;
        apIdx <= wordIndex(haddr);
        hrdata <= (hsel && htrans[1] && !hwrite) ?
                  {24'h000000, regRead(wordIndex(haddr))} : 32'h00000000;
      end
    end
  end

  // configuration writes in the data phase; wake clears like reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 11; i++) begin
        slotSel[i] <= 4'h0;
      end
      slotCount <= 4'h0;
      firLen <= 2'h0;
      diffEn <= 4'h0;
      pllFast <= 1'b0;
      adcDiv <= 1'b0;
      preEn <= 1'b0;
      rmtEn <= 3'h0;
    end else if (batteryWake) begin
      for (int i = 0; i < 11; i++) begin
        slotSel[i] <= 4'h0;
      end
      slotCount <= 4'h0;
      firLen <= 2'h0;
      diffEn <= 4'h0;
      pllFast <= 1'b0;
      adcDiv <= 1'b0;
      preEn <= 1'b0;
      rmtEn <= 3'h0;
    end else if (apValid && apWrite) begin
      case (apIdx)
        `IDX_SEL10_COUNT: begin
          slotSel[10] <= wdata[3:0];
          slotCount <= wdata[7:4];
        end
        `IDX_SEL8_9: {slotSel[9], slotSel[8]} <= wdata;
        `IDX_SEL6_7: {slotSel[7], slotSel[6]} <= wdata;
        `IDX_SEL4_5: {slotSel[5], slotSel[4]} <= wdata;
        `IDX_SEL2_3: {slotSel[3], slotSel[2]} <= wdata;
        `IDX_SEL0_1: {slotSel[1], slotSel[0]} <= wdata;
        `IDX_FIR_DIFF: begin
          firLen <= wdata[`FLD_FIR_LO +: 2];
          diffEn <= wdata[`FLD_DIFF_LO +: 4];
        end
        `IDX_CLOCKS: begin
          pllFast <= wdata[`FLD_PLL];
          adcDiv <= wdata[`FLD_ADCDIV];
        end
        `IDX_PREAMP: preEn <= wdata[`FLD_PRE];
        `IDX_REMOTE: rmtEn <= wdata[`FLD_RMT_LO +: 3];
        default: ;
      endcase
    end
  end

  // slow clock edge finder; input is already synchronous
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slowPrev <= 1'b0;
    end else begin
      slowPrev <= slowClock;
    end
  end

  // frame state machine, advanced only on slow clock rising edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SEQ_IDLE;
      currentSlot <= 4'h0;
      slotTimer <= 5'h00;
      gapTimer <= 2'h0;
      frameTick <= 9'h000;
      adcInputSelect <= 4'h0;
      convertStart <= 1'b0;
      conversionActive <= 1'b0;
      frameSync <= 1'b0;
    end else begin
      convertStart <= 1'b0;
      if (countWrite || batteryWake) begin
        // restart cleanly so a new count never lands mid frame
        state <= SEQ_IDLE;
        currentSlot <= 4'h0;
        slotTimer <= 5'h00;
        gapTimer <= 2'h0;
        frameTick <= 9'h000;
        conversionActive <= 1'b0;
        frameSync <= 1'b0;
      end else if (slowEdge) begin
        frameTick <= frameTick + 9'h001;
        case (state)
          SEQ_IDLE: begin
            if (effCount != 4'h0) begin
              state <= SEQ_CONVERT;
              currentSlot <= 4'h0;
              slotTimer <= 5'h01;
              frameTick <= 9'h000;
              adcInputSelect <= slotSel[0];
              convertStart <= 1'b1;
              conversionActive <= 1'b1;
            end
          end
          SEQ_CONVERT: begin
            if (slotTimer >= slotLenNow) begin
              if (currentSlot + 4'h1 >= effCount) begin
                state <= SEQ_SYNC;
                conversionActive <= 1'b0;
                frameSync <= 1'b1;
                gapTimer <= 2'h1;
              end else begin
                currentSlot <= currentSlot + 4'h1;
                slotTimer <= 5'h01;
                adcInputSelect <= slotSel[currentSlot + 4'h1];
                convertStart <= 1'b1;
              end
            end else begin
              slotTimer <= slotTimer + 5'h01;
            end
          end
          SEQ_SYNC: begin
            // sync pulse lasts one slow cycle; slow pll adds settle cycles
            frameSync <= 1'b0;
            if (gapTimer >= gapNow) begin
              if (effCount != 4'h0) begin
                state <= SEQ_CONVERT;
                currentSlot <= 4'h0;
                slotTimer <= 5'h01;
                frameTick <= 9'h000;
                adcInputSelect <= slotSel[0];
                convertStart <= 1'b1;
                conversionActive <= 1'b1;
              end else begin
                state <= SEQ_IDLE;
              end
            end else begin
              gapTimer <= gapTimer + 2'h1;
            end
          end
          default: state <= SEQ_IDLE;
        endcase
      end
    end
  end

  // sample RAM writes; filter results win a same-cycle clash
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sampleRamWrite <= 1'b0;
      sampleRamAddr <= 4'h0;
      sampleRamData <= 32'h00000000;
    end else begin
      sampleRamWrite <= 1'b0;
      if (firResultValid && adcInputSelect <= `MAX_HANDLE) begin
        sampleRamWrite <= 1'b1;
        sampleRamAddr <= adcInputSelect;
        sampleRamData <= {firResult[21],
                          firResult, 9'h000};
      end else if (remoteSampleValid && remoteSampleWindow &&
                   remoteSampleChannel != 2'h3 &&
                   rmtEn[remoteSampleChannel]) begin
        // remote currents bypass the mux into their pair's place
        sampleRamWrite <= 1'b1;
        sampleRamAddr <= {1'b0, remoteSampleChannel + 2'h1, 1'b0};
        sampleRamData <= {remoteSampleData[21],
                          remoteSampleData, 9'h000};
      end
    end
  end

  // second half of the running frame opens the remote window
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remoteSampleWindow <= 1'b0;
      frameFirCycles <= 16'h0000;
    end else begin
      remoteSampleWindow <= (state != SEQ_IDLE) &&
        ({frameTick, 1'b0} >= {1'b0, frameLenNow});
      frameFirCycles <= 16'(16'(frameLenNow) *
        (`FIR_BASE + (pllFast ? `FIR_FAST : 16'h0000)));
    end
  end

  // analog front end controls mirror the fields
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      differentialEnable <= 4'h0;
      remoteSensorEnable <= 3'h0;
      preampGain <= `GAIN_UNITY;
      biasReduced <= 1'b0;
      converterClockDivide <= 1'b0;
      pllFastSelect <= 1'b0;
      firLengthCode <= 2'h0;
    end else begin
      differentialEnable <= diffEn;
      remoteSensorEnable <= rmtEn;
      // gain is independent of the pair 0-1 differential bit
      preampGain <= preEn ? `GAIN_PREAMP : `GAIN_UNITY;
      biasReduced <= adcDiv;
      converterClockDivide <= adcDiv;
      pllFastSelect <= pllFast;
      firLengthCode <= firLen;
    end
  end

  sequence syncEnter;
    $rose(frameSync);
  endsequence
  sequence countWritten;
    countWrite && !batteryWake;
  endsequence

  chk_slot_select: assert property (@(posedge ref_clk) disable iff (rst)
    convertStart |-> adcInputSelect == slotSel[currentSlot])
    else $error("slot select mismatch");
  chk_zero_count: assert property (@(posedge ref_clk) disable iff (rst)
    (state == SEQ_IDLE && effCount == 4'h0) |=> !convertStart)
    else $error("conversion with zero count");
  chk_slot_limit: assert property (@(posedge ref_clk) disable iff (rst)
    conversionActive |-> currentSlot < effCount && currentSlot < 4'hB)
    else $error("slot beyond count");
  chk_ram_shift: assert property (@(posedge ref_clk) disable iff (rst)
    sampleRamWrite |-> sampleRamData[8:0] == 9'h000)
    else $error("sample not shifted");
  chk_gain_pair: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 preampGain == ($past(preEn) ? 4'h8 : 4'h1))
    else $error("preamp gain wrong");
  chk_count_idle: assert property (@(posedge ref_clk) disable iff (rst)
    countWritten |=> state == SEQ_IDLE && !conversionActive)
    else $error("count write did not idle");
  chk_sync_gap: assert property (@(posedge ref_clk) disable iff (rst)
    syncEnter |-> !conversionActive && state == SEQ_SYNC &&
      $past(state) == SEQ_CONVERT)
    else $error("sync outside frame end");
  chk_remote_window: assert property (@(posedge ref_clk) disable iff (rst)
    (sampleRamWrite && !$past(firResultValid)) |-> $past(remoteSampleWindow))
    else $error("remote write outside window");
  chk_wake_clear: assert property (@(posedge ref_clk) disable iff (rst)
    batteryWake |=> slotCount == 4'h0 && firLen == 2'h0 && rmtEn == 3'h0)
    else $error("wake left fields set");
  chk_slot_timer: assert property (@(posedge ref_clk) disable iff (rst)
    state == SEQ_CONVERT |-> slotTimer <= slotLenNow || $changed(slotLenNow))
    else $error("slot overran its length");
  chk_bias_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 biasReduced == $past(adcDiv))
    else $error("bias does not follow divide");
endmodule

// ---- pkg/adc_seq_defines.svh ----
// register indices, field positions, reset values and timing constants
// assumes: included by bare name; byte address is four times the index
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define IDX_SEL10_COUNT 16'h2100
`define IDX_SEL8_9 16'h2101
`define IDX_SEL6_7 16'h2102
`define IDX_SEL4_5 16'h2103
`define IDX_SEL2_3 16'h2104
`define IDX_SEL0_1 16'h2105
`define IDX_FIR_DIFF 16'h210C
`define IDX_CLOCKS 16'h2200
`define IDX_PREAMP 16'h2704
`define IDX_REMOTE 16'h2709
`define IDX_STATUS 16'h2110
`define FLD_FIR_LO 1
`define FLD_DIFF_LO 4
`define FLD_PLL 4
`define FLD_ADCDIV 5
`define FLD_PRE 5
`define FLD_RMT_LO 3
`define CFG_RESET 8'h00
`define MAX_SLOTS 4'hB
`define MAX_HANDLE 4'hA
`define GAP_SLOW 2'h3
`define FIR_BASE 16'h0030
`define FIR_FAST 16'h0066
`define RESULT_SHIFT 9
`define GAIN_PREAMP 4'h8
`define GAIN_UNITY 4'h1
`define SLOW_CLOCK_HZ 32768
`define REF_CLOCK_HZ 20000000
`endif

// ---- pkg/adc_seq_pkg.sv ----
// types shared by the frame sequencer and its bench
// assumes: nothing beyond a SystemVerilog compiler
package adc_seq_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CONVERT = 3'b010,
    SEQ_SYNC = 3'b100
  } seqState_t;
  typedef logic [3:0] handle_t;
  typedef logic [31:0] sample_t;
endpackage

// ---- tb/conv_far_side.sv ----
// far-side model: filter answers each conversion, remote sensor on pair 2-3
// assumes: ref_clk domain, outputs change just after the rising edge
`timescale 1ns/1ps
module conv_far_side #(
  parameter logic [3:0] FIR_DELAY = 4'h5
) (
  input wire logic ref_clk,
  input wire logic convertStart,
  input wire logic [3:0] adcInputSelect,
  input wire logic remoteSampleWindow,
  output logic [21:0] firResult,
  output logic firResultValid,
  output logic remoteSampleValid,
  output logic [1:0] remoteSampleChannel,
  output logic [21:0] remoteSampleData
);
  logic [3:0] firWait = 4'h0;
  logic [3:0] hdl = 4'h0;
  logic [1:0] winHist = 2'b00;
  initial firResult = 22'h0;
  initial remoteSampleData = 22'h0;
  // filter answers a few cycles after each start; data lines toggle when idle
  always @(posedge ref_clk) begin
    if (convertStart) firWait <= FIR_DELAY;
    else if (firWait != 4'h0) firWait <= firWait - 4'h1;
    if (convertStart) hdl <= adcInputSelect;
    firResultValid <= (firWait == 4'h1);
    firResult <= (firWait == 4'h1) ? {~hdl[0], 13'h1A5C, 4'h0, hdl}
                                   : ~firResult;
  end
  // one remote sample two cycles after the window opens, never at a start
  always @(posedge ref_clk) begin
    winHist <= {winHist[0], remoteSampleWindow};
    remoteSampleValid <= (winHist == 2'b01);
    remoteSampleChannel <= 2'h0;
    remoteSampleData <= (winHist == 2'b01) ? 22'h2A5A5 : ~remoteSampleData;
  end
endmodule

// ---- tb/adc_mux_frame_sequencer_tb.sv ----
// self-checking bench: register bus, frame timing, slot selects, sample RAM
// assumes: design and far-side model compiled first; slow clock scaled down
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module adc_mux_frame_sequencer_tb;
  import adc_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic batteryWake = 1'b0;
  logic [2:0] slowDiv = 3'h0;
  logic slowClock, hready, hwrite = 1'b0, hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, remoteSampleChannel, firLengthCode;
  logic [2:0] hsize = 3'h2, remoteSensorEnable;
  logic hreadyout, hresp, firResultValid, remoteSampleValid, convertStart;
  logic conversionActive, frameSync, remoteSampleWindow, sampleRamWrite;
  logic biasReduced, converterClockDivide, pllFastSelect;
  logic [21:0] firResult, remoteSampleData;
  handle_t adcInputSelect, sampleRamAddr;
  sample_t sampleRamData;
  logic [3:0] currentSlot, differentialEnable, preampGain;
  logic [15:0] frameFirCycles;
  int mismatches = 0, cmp_count = 0;
  localparam logic [15:0] IDX [10] = '{`IDX_SEL10_COUNT, `IDX_SEL8_9,
    `IDX_SEL6_7, `IDX_SEL4_5, `IDX_SEL2_3, `IDX_SEL0_1, `IDX_FIR_DIFF,
    `IDX_CLOCKS, `IDX_PREAMP, `IDX_REMOTE};
  localparam logic [7:0] MSK [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hF6, 8'h30, 8'h20, 8'h38};
  // slow clock is eight ref cycles long so whole frames fit a short run
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) slowDiv <= slowDiv + 3'h1;
  assign slowClock = slowDiv[2];
  assign hready = hreadyout;
  adc_mux_frame_sequencer DUT (.ref_clk, .rst, .batteryWake, .slowClock,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .firResult, .firResultValid, .remoteSampleValid,
    .remoteSampleChannel, .remoteSampleData, .adcInputSelect, .convertStart,
    .conversionActive, .frameSync, .currentSlot, .remoteSampleWindow,
    .sampleRamWrite, .sampleRamAddr, .sampleRamData, .differentialEnable,
    .remoteSensorEnable, .preampGain, .biasReduced, .converterClockDivide,
    .pllFastSelect, .firLengthCode, .frameFirCycles);
  conv_far_side far (.ref_clk, .convertStart, .adcInputSelect,
    .remoteSampleWindow, .firResult, .firResultValid, .remoteSampleValid,
    .remoteSampleChannel, .remoteSampleData);
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for the edge at which hready is sampled high
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr,
                     input logic [7:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rd_check(input logic [15:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    bus(idx, 1'b0, 8'h00, r);
    check(r, {24'h0, exp});
    check(hresp, 1'b0);
  endtask
  // reset values, read/write, unmapped place, wake clear, zero count idle
  task automatic scen_regs();
    logic [31:0] r;
    int n;
    for (int i = 0; i < 10; i++) rd_check(IDX[i], 8'h00);
    // slot count goes last so no field changes under a running frame
    for (int i = 9; i >= 0; i--) begin
      bus(IDX[i], 1'b1, MSK[i], r);
      rd_check(IDX[i], MSK[i]);
    end
    rd_check(16'h2106, 8'h00);
    batteryWake <= 1'b1;
    @(posedge ref_clk);
    batteryWake <= 1'b0;
    for (int i = 0; i < 10; i++) rd_check(IDX[i], 8'h00);
    n = 0;
    repeat (200) begin
      @(posedge ref_clk);
      if (convertStart !== 1'b0) n++;
    end
    check(n, 0);
    rd_check(`IDX_STATUS, 8'h00);
  endtask
  function automatic logic [3:0] hx(input int i);
    return (i < 8) ? 4'(7 - i) : 4'(i);
  endfunction
  // program a frame, then time every slot start and check each sample
  task automatic scen_frame(input int f, input int d, input int p,
                            input int cnt, input logic pre, input logic rmt);
    logic [31:0] r, expData;
    logic [3:0] dif;
    logic [3:0] h[$];
    logic pv, pr, win0;
    int t[$];
    int fs, rw, n, L, gap;
    L = (3 - 2 * p) * (f + 1) * (d + 1);
    gap = 3 - 2 * p;
    dif = p ? 4'hA : 4'h5;
    bus(`IDX_SEL10_COUNT, 1'b1, 8'h00, r);
    bus(`IDX_FIR_DIFF, 1'b1, {dif, 1'b0, 2'(f), 1'b0}, r);
    bus(`IDX_CLOCKS, 1'b1, {2'b00, 1'(d), 1'(p), 4'h0}, r);
    bus(`IDX_PREAMP, 1'b1, {2'b00, pre, 5'h00}, r);
    bus(`IDX_REMOTE, 1'b1, {2'b00, 2'b00, rmt, 3'h0}, r);
    bus(`IDX_SEL0_1, 1'b1, 8'h67, r);
    bus(`IDX_SEL2_3, 1'b1, 8'h45, r);
    bus(`IDX_SEL4_5, 1'b1, 8'h23, r);
    bus(`IDX_SEL6_7, 1'b1, 8'h01, r);
    bus(`IDX_SEL8_9, 1'b1, 8'h98, r);
    repeat (2) @(posedge ref_clk);
    check(differentialEnable, dif);
    check(remoteSensorEnable, {2'b00, rmt});
    check(preampGain, pre ? 8 : 1);
    check(biasReduced, d);
    check({converterClockDivide, pllFastSelect}, d * 2 + p);
    check(firLengthCode, f);
    bus(`IDX_SEL10_COUNT, 1'b1, {4'(cnt), 4'hA}, r);
    pv = 1'b0;
    pr = 1'b0;
    win0 = 1'b0;
    fs = -1;
    rw = 0;
    n = 0;
    while (t.size() < cnt + 2 && n < 2000) begin
      @(posedge ref_clk);
      n++;
      if (pv && h.size() > 0) begin
        check(sampleRamWrite, 1'b1);
        check(sampleRamAddr, h[h.size() - 1]);
        check(sampleRamData, expData);
      end
      if (pr) begin
        check({sampleRamWrite, sampleRamAddr}, 5'h12);
        rw++;
      end
      pv = firResultValid;
      pr = remoteSampleValid & rmt;
      expData = {firResult[21], firResult, 9'h000};
      if (convertStart === 1'b1) begin
        if (t.size() == 0) win0 = remoteSampleWindow;
        check({conversionActive, currentSlot},
              {1'b1, 4'(t.size() % cnt)});
        t.push_back(n);
        h.push_back(adcInputSelect);
      end
      if (frameSync === 1'b1 && fs < 0 && t.size() > 0) fs = n;
    end
    if (t.size() < cnt + 2) begin
      mismatches++;
      final_report();
    end
    check(h[0], hx(0));
    for (int i = 1; i <= cnt + 1; i++) begin
      check(t[i] - t[i - 1], ((i % cnt) == 0 ? L + gap : L) * 8);
      check(h[i], hx(i % cnt));
    end
    check(t[cnt] - t[0], (gap + L * cnt) * 8);
    check(fs - t[cnt - 1], L * 8);
    check(frameFirCycles, (gap + L * cnt) * (48 + 102 * p));
    check(win0, 1'b0);
    check(rw > 0, rmt);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    scen_regs();
    scen_frame(1, 0, 0, 3, 1'b0, 1'b0);
    scen_frame(2, 1, 1, 11, 1'b1, 1'b1);
    final_report();
  end
endmodule
